// [common/icb_pkg.sv]
// Constants and carrier types for the channel burst and blast logic.
// Assumes one 20 MHz clock; pin polarities are active high inside, except the active-low reset rst_b.
package icb_pkg;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam int BLAST_MIN_NS = 800;
   localparam int BLAST_CYC = (BLAST_MIN_NS + CLK_PERIOD_NS - 1) /
                              CLK_PERIOD_NS;
   localparam int TIMEOUT_NS = 100000;
   localparam int TMO_CYC = TIMEOUT_NS / CLK_PERIOD_NS;
   localparam int MAX_BURST_BYTES = 256;

   // ------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------
   localparam int ID_W = 8;
   localparam int ARS_W = 3;
   localparam int TAG_W = 4;
   localparam int BUS_W = 16;

   // ------------------------------------------------------------
   // Error byte bit positions and reset values
   // ------------------------------------------------------------
   localparam int ERR_PARITY = 0;
   localparam int ERR_BAD_ADDR = 1;
   localparam int ERR_TIMEOUT = 2;
   localparam int ERR_HOG = 3;
   localparam int ERR_INCOMPLETE = 4;
   localparam logic [7:0] ERR_RST = 8'h00;
   localparam logic [15:0] CHREG_RST = 16'h0000;

   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic burst;
      logic svc_in;
      logic cs_req;
      logic multi_resp;
      logic xfer_in;
      logic [ARS_W-1:0] ars;
      logic [TAG_W-1:0] tag;
   } icb_att_t;

   typedef struct packed {
      logic ctl_out;
      logic svc_out;
      logic strobe;
   } icb_chn_t;
endpackage

// [design/icb_prio_pick.sv]
// Fixed-priority picker: keeps the lowest-numbered set request bit.
// Assumes bit 0 has the highest priority; purely combinational.
`timescale 1ns/1ps
module icb_prio_pick #(
   parameter int W = 8
) (
   // Requests
   input wire logic [W-1:0] req,
   // Result
   output logic [W-1:0] onehot,
   output logic any
);
   // ------------------------------------------------------------
   // One bit wins
   // ------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         if (i == 0) begin : g_first
            assign onehot[i] = req[i];
         end else begin : g_rest
            assign onehot[i] = req[i] & ~(|req[i-1:0]);
         end
      end
   endgenerate
   assign any = |req;
endmodule

// [design/icb_channel.sv]
// Channel side of the multiple-byte cycle steal, error capture and blast.
// Assumes attachment inputs are synchronous to clk, active high.
// What this block and the attachment do
// [RL1] Attachment acknowledges then requests after selection
// [RL2] Control line drops; attachment lines then valid
// [RL3] Grant, storage access, drive output data
// [RL4] Attachment repeats data phases under grant
// [RL5] Ack then request drop; grant drops
// [RL6] Error sets error byte, raises check
// [RL7] No transfers until check acknowledged
// [RL8] Error byte and register hold until clear
// [RL9] Processor reads, clears and retries
// [RL10] Blast: control and grant, strobe idle
// [RL11] Blast on parity, address, timeout, hog, failure
// [RL12] Blast lasts at least 800 ns
// [RL13] Blast entry: grant first, control second
// [RL14] Attachment releases bus on blast
// [RL15] Attachment keeps requests asserted in blast
// [RL16] Blast ends dropping grant and control
// [RL17] Unrecoverable error raises processor check
// [RL18] One or two bytes per strobe, 256 max
// [RL19] Highest-priority identifier echoed on upper lines
// [RL20] Handshake timeout counter triggers blast
`timescale 1ns/1ps
module icb_channel #(
   parameter int MAX_BYTES = icb_pkg::MAX_BURST_BYTES,
   parameter int TMO = icb_pkg::TMO_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Attachment lines
   input wire icb_pkg::icb_att_t att_i,
   input wire logic [15:0] bidi_in,
   input wire logic [1:0] bidi_par,
   output logic [15:0] bidi_out,
   output logic bidi_oe,
   output icb_pkg::icb_chn_t chn_o,
   // Storage access
   output logic stor_req,
   output logic stor_wr,
   output logic stor_two,
   output logic [icb_pkg::ARS_W-1:0] stor_sel,
   output logic [15:0] stor_wdata,
   input wire logic [15:0] stor_rdata,
   input wire logic stor_done,
   // Control processor
   input wire logic two_byte,
   input wire logic io_fail,
   input wire logic halt_req,
   input wire logic chk_ack,
   input wire logic err_clr,
   output logic chan_check,
   output logic proc_check,
   output logic cpu_hold,
   output logic [7:0] err_byte,
   output logic [15:0] chan_reg
);
   localparam int TW = $clog2(TMO) + 1;
   localparam int BCW = $clog2(icb_pkg::BLAST_CYC) + 1;
   localparam logic [TW-1:0] TMO_LAST = TW'(TMO - 1);
   localparam logic [BCW-1:0] BLAST_LAST = BCW'(icb_pkg::BLAST_CYC - 1);
   localparam logic [9:0] MAX_B = 10'(MAX_BYTES);

   typedef enum logic [3:0] {
      S_IDLE, S_SENSE, S_ID, S_SEL, S_WAIT_REQ, S_SETTLE, S_XFER,
      S_ACCESS, S_STROBE, S_END, S_BLAST_G, S_BLAST_C
   } icb_state_t;

   icb_state_t st_q, st_d;
   icb_pkg::icb_chn_t ch_q, ch_d;
   logic [15:0] out_q, out_d, wdata_q, wdata_d, chreg_q, chreg_d;
   logic oe_q, oe_d, req_q, req_d, wr_q, wr_d, two_q, two_d;
   logic [icb_pkg::ARS_W-1:0] sel_q, sel_d;
   logic [7:0] id_q, id_d, err_q, err_d, err_vec;
   logic [8:0] cnt_q, cnt_d;
   logic [TW-1:0] tmo_q, tmo_d;
   logic [BCW-1:0] bcnt_q, bcnt_d;
   logic chk_q, chk_d, pchk_q, pchk_d, hold_q, hold_d;
   logic svc_prev_q, cs_prev_q;

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   wire logic [7:0] pick;
   wire logic pick_any;
   wire logic in_blast = (st_q == S_BLAST_G) || (st_q == S_BLAST_C);
   wire logic busy = (st_q != S_IDLE) && !in_blast;
   wire logic refuse = chk_q || pchk_q; // [RL7]
   wire logic [9:0] nb = two_byte ? 10'h002 : 10'h001; // [RL18]
   wire logic over = (10'({1'b0, cnt_q}) + nb) > MAX_B; // [RL18]
   wire logic par_bad = !(^{bidi_in[7:0], bidi_par[0]}) ||
      (two_byte && !(^{bidi_in[15:8], bidi_par[1]}));
   wire logic hs_edge = (att_i.svc_in != svc_prev_q) ||
      (att_i.cs_req != cs_prev_q) || (st_d != st_q); // [RL20]
   wire logic tmo_hit = busy && (tmo_q == TMO_LAST);

   // Blast sources; io_fail counts even from idle
   assign err_vec[icb_pkg::ERR_PARITY] = (st_q == S_XFER) &&
      att_i.xfer_in && par_bad; // [RL11]
   assign err_vec[icb_pkg::ERR_BAD_ADDR] = (st_q == S_SEL) && !pick_any;
   assign err_vec[icb_pkg::ERR_TIMEOUT] = tmo_hit; // [RL20]
   assign err_vec[icb_pkg::ERR_HOG] = (st_q == S_XFER) && over;
   assign err_vec[icb_pkg::ERR_INCOMPLETE] = io_fail && !in_blast;
   assign err_vec[7:5] = 3'h0;
   wire logic err_hit = |err_vec; // [RL11]

   icb_prio_pick #(.W(icb_pkg::ID_W)) u_pick (
      .req(bidi_in[7:0]),
      .onehot(pick),
      .any(pick_any)
   );

   // ------------------------------------------------------------
   // Error capture: set wins over clear
   // ------------------------------------------------------------
   assign err_d = (err_clr ? icb_pkg::ERR_RST : err_q) | err_vec; // [RL6]
   assign chreg_d = (err_hit && (err_q == 8'h00 || err_clr)) ?
      {id_q, att_i.tag, att_i.ars, att_i.xfer_in} :
      (err_clr ? icb_pkg::CHREG_RST : chreg_q); // [RL8]
   assign chk_d = err_hit || (chk_q && !chk_ack); // [RL6] [RL9]
   assign pchk_d = pchk_q || halt_req; // [RL17]
   assign hold_d = (st_d != S_IDLE) || pchk_d;
   assign tmo_d = (!busy || hs_edge) ? '0 : tmo_q + TW'(1); // [RL20]

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      ch_d = ch_q;
      ch_d.strobe = 1'b0;
      out_d = out_q;
      oe_d = oe_q;
      req_d = req_q;
      wr_d = wr_q;
      two_d = two_q;
      sel_d = sel_q;
      wdata_d = wdata_q;
      id_d = id_q;
      cnt_d = cnt_q;
      bcnt_d = bcnt_q;
      if (err_hit) begin
         // Grant goes up alone first
         st_d = S_BLAST_G;
         ch_d.ctl_out = 1'b0;
         ch_d.svc_out = 1'b1; // [RL13]
         oe_d = 1'b0;
         req_d = 1'b0;
      end else begin
         case (st_q)
            S_IDLE: begin
               cnt_d = 9'h000;
               if (att_i.burst && !refuse) begin // [RL7]
                  ch_d.ctl_out = 1'b1;
                  st_d = S_SENSE;
               end
            end
            S_SENSE: begin
               ch_d.strobe = 1'b1;
               st_d = S_ID;
            end
            S_ID: st_d = S_SEL;
            S_SEL: begin
               id_d = pick;
               out_d = {pick, 8'h00}; // [RL19]
               oe_d = 1'b1;
               ch_d.strobe = 1'b1;
               st_d = S_WAIT_REQ;
            end
            S_WAIT_REQ: begin
               if (att_i.svc_in && att_i.cs_req) begin
                  ch_d.ctl_out = 1'b0; // [RL2]
                  oe_d = 1'b0;
                  st_d = S_SETTLE;
               end
            end
            // Gives the attachment a cycle to make its lines valid
            S_SETTLE: begin
               oe_d = 1'b0;
               st_d = S_XFER;
            end
            S_XFER: begin
               ch_d.svc_out = 1'b1; // [RL3]
               req_d = 1'b1;
               wr_d = att_i.xfer_in;
               two_d = two_byte;
               sel_d = att_i.ars;
               wdata_d = two_byte ? bidi_in : {8'h00, bidi_in[7:0]};
               cnt_d = cnt_q + 9'(nb); // [RL18]
               st_d = S_ACCESS;
            end
            S_ACCESS: begin
               if (stor_done) begin
                  req_d = 1'b0;
                  if (!wr_q) begin
                     out_d = stor_rdata; // [RL3]
                     oe_d = 1'b1;
                  end
                  ch_d.strobe = 1'b1;
                  st_d = S_STROBE;
               end
            end
            S_STROBE: begin
               oe_d = 1'b0;
               st_d = att_i.svc_in ? S_SETTLE : S_END; // [RL4]
            end
            S_END: begin
               if (!att_i.cs_req) begin
                  ch_d.svc_out = 1'b0; // [RL5]
                  st_d = S_IDLE;
               end
            end
            S_BLAST_G: begin
               ch_d.ctl_out = 1'b1; // [RL13] [RL10]
               bcnt_d = '0;
               st_d = S_BLAST_C;
            end
            S_BLAST_C: begin
               if (bcnt_q == BLAST_LAST) begin // [RL12]
                  ch_d.ctl_out = 1'b0; // [RL16]
                  ch_d.svc_out = 1'b0;
                  st_d = S_IDLE;
               end else begin
                  bcnt_d = bcnt_q + BCW'(1);
               end
            end
            default: st_d = S_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= S_IDLE;
         ch_q <= '0;
         out_q <= 16'h0000;
         oe_q <= 1'b0;
         req_q <= 1'b0;
         wr_q <= 1'b0;
         two_q <= 1'b0;
         sel_q <= '0;
         wdata_q <= 16'h0000;
         id_q <= 8'h00;
         cnt_q <= 9'h000;
         bcnt_q <= '0;
         tmo_q <= '0;
      end else begin
         st_q <= st_d;
         ch_q <= ch_d;
         out_q <= out_d;
         oe_q <= oe_d;
         req_q <= req_d;
         wr_q <= wr_d;
         two_q <= two_d;
         sel_q <= sel_d;
         wdata_q <= wdata_d;
         id_q <= id_d;
         cnt_q <= cnt_d;
         bcnt_q <= bcnt_d;
         tmo_q <= tmo_d;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         err_q <= icb_pkg::ERR_RST;
         chreg_q <= icb_pkg::CHREG_RST;
         chk_q <= 1'b0;
         pchk_q <= 1'b0;
         hold_q <= 1'b0;
         svc_prev_q <= 1'b0;
         cs_prev_q <= 1'b0;
      end else begin
         err_q <= err_d;
         chreg_q <= chreg_d;
         chk_q <= chk_d;
         pchk_q <= pchk_d;
         hold_q <= hold_d;
         svc_prev_q <= att_i.svc_in;
         cs_prev_q <= att_i.cs_req;
      end
   end

   assign chn_o = ch_q;
   assign bidi_out = out_q;
   assign bidi_oe = oe_q;
   assign stor_req = req_q;
   assign stor_wr = wr_q;
   assign stor_two = two_q;
   assign stor_sel = sel_q;
   assign stor_wdata = wdata_q;
   assign chan_check = chk_q;
   assign proc_check = pchk_q;
   assign cpu_hold = hold_q;
   assign err_byte = err_q;
   assign chan_reg = chreg_q;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   wire logic blast = ch_q.ctl_out && ch_q.svc_out;
   sequence blast_held;
      blast [*8] ##1 blast [*8];
   endsequence
   sequence blast_gone;
      !ch_q.ctl_out && !ch_q.svc_out;
   endsequence

   AST_BLAST_LEN: assert property ($rose(blast) |-> blast_held) // [RL12]
      else $error("blast shorter than minimum");
   AST_BLAST_END: assert property ($rose(blast) |-> ##16 blast_gone) // [RL16]
      else $error("blast not ended by dropping both lines");
   AST_BLAST_STB: assert property (blast |-> !ch_q.strobe) // [RL10]
      else $error("strobe active during blast");
   AST_BLAST_ORDER: assert property ($rose(blast) |->
      $past(ch_q.svc_out) && !$past(ch_q.ctl_out)) // [RL13]
      else $error("control rose before grant in blast");
   AST_ERR_BLAST: assert property (err_hit |=> chan_check ##1 $rose(blast)) // [RL6]
      else $error("error did not raise check and blast");
   // A failed operation may still blast while the check is pending
   AST_REFUSE: assert property (chan_check && st_q == S_IDLE |=>
      st_q inside {S_IDLE, S_BLAST_G}) // [RL7]
      else $error("burst started while check pending");
   AST_HOLD: assert property (!err_clr && !err_hit |=> $stable(err_byte)
      && $stable(chan_reg)) // [RL8]
      else $error("error record changed without cause");
   AST_GRANT_CTL: assert property ($rose(ch_q.svc_out) && !ch_q.ctl_out
      |-> $past(st_q) == S_XFER || st_q == S_BLAST_G) // [RL2] [RL3]
      else $error("grant rose outside data phase");
   AST_END: assert property (st_q == S_END && !att_i.cs_req && !err_hit
      |=> !ch_q.svc_out) // [RL5]
      else $error("grant held after request dropped");
   AST_PICK: assert property (st_q == S_WAIT_REQ && $past(st_q) == S_SEL
      |-> $onehot(bidi_out[15:8]) && bidi_oe) // [RL19]
      else $error("selection not one-hot on upper lines");
   AST_TMO: assert property (tmo_hit |=> err_byte[icb_pkg::ERR_TIMEOUT]) // [RL20]
      else $error("timeout not recorded");
   AST_PCHK: assert property (halt_req |=> proc_check && cpu_hold) // [RL17]
      else $error("processor check not raised");
   AST_COUNT: assert property (st_q == S_ACCESS |-> cnt_q <= 9'(MAX_BYTES)) // [RL18]
      else $error("burst byte count exceeded");
endmodule

// [tb/icb_att_model.sv]
// Attachment model: bids, takes the grant, runs a burst, obeys blast.
// Assumes channel pins active high and synchronous to clk.
`timescale 1ns/1ps
module icb_att_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Channel side
   input wire icb_pkg::icb_chn_t chn,
   input wire logic [15:0] bus_o,
   input wire logic bus_oe,
   output icb_pkg::icb_att_t att,
   output logic [15:0] drv,
   output logic [1:0] par,
   // Test knobs
   input wire logic go,
   input wire logic [7:0] mask,
   input wire logic [7:0] dly,
   input wire logic [8:0] nx,
   input wire logic xin,
   input wire logic bad_par,
   input wire logic [15:0] base
);
   logic [2:0] st_q;
   logic [8:0] k_q;
   logic [7:0] w_q;
   logic [15:0] junk_q;
   logic [15:0] d;
   logic blast;
   logic won;
   assign blast = chn.ctl_out & chn.svc_out & ~chn.strobe;
   assign won = chn.strobe & bus_oe & |(bus_o[15:8] & mask);
   assign d = base + 16'(k_q);
   // Released lines toggle, so stale data never looks valid
   assign drv = (st_q == 3'h1) ? {8'h00, mask} :
                (st_q == 3'h3 && att.xfer_in) ? d : junk_q;
   assign par = {~^d[15:8], ~^d[7:0] ^ bad_par};
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= 3'h0;
         att <= '0;
         k_q <= '0;
         w_q <= '0;
         junk_q <= 16'h0000;
      end else begin
         junk_q <= ~junk_q;
         if (blast && st_q != 3'h5) begin
            att <= '{cs_req: att.cs_req, default: '0};
            st_q <= 3'h5;
         end else begin
            case (st_q)
               3'h0: if (go) begin
                  att.burst <= 1'h1;
                  st_q <= 3'h1;
               end
               3'h1: if (!go) begin
                  att.burst <= 1'h0;
                  st_q <= 3'h0;
               end else if (won) begin
                  w_q <= dly;
                  st_q <= 3'h2;
               end
               3'h2: if (w_q != 8'h00) begin
                  w_q <= w_q - 8'h01;
               end else begin
                  att.svc_in <= 1'h1;
                  att.cs_req <= 1'h1;
                  att.xfer_in <= xin;
                  att.ars <= base[2:0];
                  att.tag <= base[6:3];
                  k_q <= '0;
                  st_q <= 3'h3;
               end
               3'h3: begin
                  if (chn.strobe && chn.svc_out) begin
                     k_q <= k_q + 9'h001;
                     if (k_q + 9'h001 == nx) begin
                        st_q <= 3'h4;
                     end
                  end
                  // Channel decides on the edge that ends a strobe, so
                  // acknowledge drops once the last transfer is under way
                  if (!chn.ctl_out && k_q == nx - 9'h001) begin
                     att.svc_in <= 1'h0;
                  end
               end
               3'h4: begin
                  att.cs_req <= 1'h0;
                  att.burst <= 1'h0;
                  st_q <= 3'h0;
               end
               default: if (!chn.ctl_out && !chn.svc_out) begin
                  att.cs_req <= 1'h0;
                  st_q <= 3'h0;
               end
            endcase
         end
      end
   end
endmodule

// [tb/io_channel_burst_steal_and_blast_tb_top.sv]
// Self-checking bench: bursts, errors, blast, halt of the channel.
// Assumes icb_att_model on the far side and a 20 MHz clock.
`timescale 1ns/1ps
module io_channel_burst_steal_and_blast_tb_top;
   localparam int LIMIT = 40000;
   logic clk = 1'h0;
   logic rst_b = 1'h0;
   icb_pkg::icb_att_t att;
   icb_pkg::icb_chn_t chn;
   logic [15:0] bidi_in, bidi_out, drv, stor_wdata, chan_reg;
   logic [15:0] stor_rdata = 16'h0000;
   logic [15:0] base = 16'h0000;
   logic [1:0] bidi_par;
   logic [2:0] stor_sel;
   logic [7:0] err_byte;
   logic [7:0] mask = 8'h01;
   logic [7:0] dly = 8'h00;
   logic [8:0] nx = 9'h001;
   logic bidi_oe, stor_req, stor_wr, stor_two, chan_check, proc_check;
   logic cpu_hold, rq_q, bl_q, sc_q, svc_q, ctl_q;
   logic stor_done = 1'h0, two_byte = 1'h0, io_fail = 1'h0;
   logic halt_req = 1'h0, chk_ack = 1'h0, err_clr = 1'h0;
   logic go = 1'h0, xin = 1'h0, bad_par = 1'h0;
   int seed = 55096, error_cnt = 0, checked = 0, cyc = 0;
   int nreq = 0, nblast = 0, blen = 0, sdw = 0;
   assign bidi_in = bidi_oe ? bidi_out : drv;
   always #25 clk = ~clk;

   icb_channel #(.MAX_BYTES(256), .TMO(40)) uut (.clk(clk), .rst_b(rst_b),
      .att_i(att), .bidi_in(bidi_in), .bidi_par(bidi_par),
      .bidi_out(bidi_out), .bidi_oe(bidi_oe), .chn_o(chn),
      .stor_req(stor_req), .stor_wr(stor_wr), .stor_two(stor_two),
      .stor_sel(stor_sel), .stor_wdata(stor_wdata),
      .stor_rdata(stor_rdata), .stor_done(stor_done),
      .two_byte(two_byte), .io_fail(io_fail), .halt_req(halt_req),
      .chk_ack(chk_ack), .err_clr(err_clr), .chan_check(chan_check),
      .proc_check(proc_check), .cpu_hold(cpu_hold), .err_byte(err_byte),
      .chan_reg(chan_reg));
   icb_att_model p (.clk(clk), .rst_b(rst_b), .chn(chn), .bus_o(bidi_out),
      .bus_oe(bidi_oe), .att(att), .drv(drv), .par(bidi_par), .go(go),
      .mask(mask), .dly(dly), .nx(nx), .xin(xin), .bad_par(bad_par),
      .base(base));

   function automatic logic [7:0] pick(input logic [7:0] m);
      return m & (~m + 8'h01);
   endfunction
   function automatic logic [15:0] lane(input logic [15:0] v);
      return two_byte ? v : {8'h00, v[7:0]};
   endfunction
   task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tick;
      @(posedge clk);
      #1;
   endtask
   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Monitors and storage responder
   // ------------------------------------------------------------
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         error_cnt++;
         wrap_up();
      end
      if (sc_q && !chn.svc_out) cmp("ctl_out", 0, chn.ctl_out);
      if (chn.strobe && bidi_oe && !chn.svc_out)
         cmp("pick", pick(mask), bidi_out[15:8]);
      if (chn.strobe && chn.svc_out && !xin)
         cmp("out", lane(stor_rdata), lane(bidi_out));
      if (stor_req && !rq_q) begin
         cmp("wr", xin, stor_wr);
         cmp("sel", base[2:0], stor_sel);
         cmp("two", two_byte, stor_two);
         if (xin) cmp("wdata", lane(base + 16'(nreq)), stor_wdata);
         nreq++;
      end
      stor_done <= 1'h0;
      if (stor_req && !stor_done) begin
         if (sdw == 0) begin
            stor_done <= 1'h1;
            stor_rdata <= 16'($random(seed));
            sdw = $random(seed) & 3;
         end else begin
            sdw--;
         end
      end
      if (chn.ctl_out && chn.svc_out) begin
         blen++;
         cmp("strobe", 0, chn.strobe);
         if (!bl_q) cmp("entry", 2'h2, {svc_q, ctl_q});
      end else if (bl_q) begin
         cmp("blast_len", icb_pkg::BLAST_CYC, blen);
         cmp("blast_end", 0, {chn.ctl_out, chn.svc_out});
         nblast++;
         blen = 0;
      end
      bl_q <= chn.ctl_out & chn.svc_out;
      svc_q <= chn.svc_out;
      ctl_q <= chn.ctl_out;
      rq_q <= stor_req;
      sc_q <= att.svc_in & att.cs_req;
   end

   // ------------------------------------------------------------
   // Scenario tasks
   // ------------------------------------------------------------
   task automatic start(int n, logic x, logic two, logic [7:0] m,
                        logic [7:0] dl);
      @(posedge clk);
      nx <= 9'(n);
      xin <= x;
      two_byte <= two;
      mask <= m;
      dly <= dl;
      base <= 16'($random(seed));
      go <= 1'h1;
      nreq = 0;
   endtask
   task automatic run_burst(int n, logic x, logic two);
      int t = 0;
      start(n, x, two, 8'($random(seed)) | 8'h80, 8'($random(seed)) & 8'h03);
      while (p.st_q != 3'h4 && t < 8000) begin
         tick;
         t++;
      end
      go <= 1'h0;
      repeat (4) tick;
      cmp("svc_out", 0, chn.svc_out);
      cmp("xfers", n, nreq);
   endtask
   task automatic err_case(int b, logic rchk, logic [15:0] r);
      int t = 0;
      int nb = nblast;
      while (!chan_check && t < 8000) begin
         tick;
         t++;
      end
      cmp("err_bit", 1, err_byte[b]);
      if (rchk) cmp("chan_reg", r, chan_reg);
      t = 0;
      while (nblast == nb && t < 100) begin
         tick;
         t++;
      end
      cmp("blasts", nb + 1, nblast);
      repeat (12) begin
         tick;
         cmp("refused", 0, chn.ctl_out);
      end
      go <= 1'h0;
      bad_par <= 1'h0;
      chk_ack <= 1'h1;
      tick;
      chk_ack <= 1'h0;
      tick;
      cmp("chk", 0, chan_check);
      cmp("held", 1, err_byte[b]);
      err_clr <= 1'h1;
      tick;
      err_clr <= 1'h0;
      tick;
      cmp("clr", 0, {err_byte, chan_reg});
   endtask

   initial begin
      repeat (5) @(posedge clk);
      rst_b <= 1'h1;
      cmp("rst", 0, {chn, bidi_oe, stor_req, chan_check, cpu_hold});
      tick;
      cmp("rst_err", {icb_pkg::ERR_RST, icb_pkg::CHREG_RST},
          {err_byte, chan_reg});
      for (int i = 0; i < 8; i++)
         run_burst(1 + ($unsigned($random(seed)) % 8), 1'($random(seed)),
                   1'($random(seed)));
      run_burst(256, 1'h1, 1'h0);
      run_burst(128, 1'h0, 1'h1);
      start(1, 1'h0, 1'h1, 8'h00, 8'h00);
      err_case(icb_pkg::ERR_BAD_ADDR, 1'h0, 16'h0000);
      start(2, 1'h1, 1'h1, 8'h0C, 8'h00);
      bad_par <= 1'h1;
      // New base must land before the expectation reads it
      tick;
      err_case(icb_pkg::ERR_PARITY, 1'h1,
               {8'h04, base[6:3], base[2:0], 1'h1});
      start(1, 1'h0, 1'h1, 8'h02, 8'hFF);
      err_case(icb_pkg::ERR_TIMEOUT, 1'h0, 16'h0000);
      start(129, 1'h0, 1'h1, 8'h01, 8'h00);
      err_case(icb_pkg::ERR_HOG, 1'h0, 16'h0000);
      io_fail <= 1'h1;
      tick;
      io_fail <= 1'h0;
      err_case(icb_pkg::ERR_INCOMPLETE, 1'h0, 16'h0000);
      halt_req <= 1'h1;
      tick;
      halt_req <= 1'h0;
      tick;
      cmp("halt", 2'h3, {proc_check, cpu_hold});
      start(1, 1'h0, 1'h1, 8'h01, 8'h00);
      repeat (10) begin
         tick;
         cmp("halted", 0, chn.ctl_out);
      end
      wrap_up();
   end
endmodule
